/* logic/tmps_pkg.sv */
// constants shared by the timed mailbox poll scheduler
// assumes a single 25 MHz system clock and one serial port per instance
package tmps_pkg;
	localparam int          CLK_HZ          = 25_000_000;              // system clock rate
	localparam int          TICK_MS         = 10;                      // interval unit, milliseconds
	localparam int          TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS; // clocks per tick
	localparam int          HOLD_MS         = 2000;                    // extra delay after a late reply
	localparam logic [15:0] HOLD_TICKS      = 16'(HOLD_MS / TICK_MS);  // same delay in ticks
	localparam int          ENTRIES         = 48;                      // scan table depth
	localparam int          IDX_W           = 6;                       // table index width
	localparam int          LOC_W           = 12;                      // mailbox address width
	localparam int          REM_W           = 14;                      // remote register width
	localparam int          CNT_W           = 8;                       // word count width
	localparam int          RTE_W           = 8;                       // first route drop width
	localparam int          IVL_W           = 16;                      // interval width
	localparam logic [LOC_W-1:0] LOC_MAX    = 12'h800;                 // top mailbox word
	localparam logic [REM_W-1:0] REM_MAX    = 14'h2000;                // top remote register
	localparam logic [CNT_W-1:0] CNT_MAX    = 8'h80;                   // largest word count
	localparam logic [IVL_W-1:0] IVL_OFF    = 16'h0000;                // interval that disables all
	localparam logic        DIR_READ        = 1'b0;                    // remote into mailbox
	localparam logic        DIR_WRITE       = 1'b1;                    // mailbox out to remote
	localparam int          MSG_W           = 1 + LOC_W + REM_W + CNT_W + RTE_W + 1 + IDX_W;
	typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT, ST_HOLD} tmps_state_t;
endpackage

/* logic/tmps_sched.sv */
// timed mailbox poll scheduler: auto-transfer and 48-entry auto-scan for one port
// assumes configuration and reply inputs come from logic on MCLK (no synchronisers)
//
// Function
// - space messages by interval in 10 ms ticks
// - alternate read and write when both enabled
// - late reply adds two second delay
// - zero interval disables auto-transfer
// - zero interval disables whole scan table
// - read count at most 128, zero suppresses
// - read destination mailbox address 1 to 2048
// - write count 0 to 128, zero suppresses
// - one read, one write, one fixed route
// - write moves mailbox words from local start
// - own table of 48 entries per port
// - disabled entries skipped without an interval
// - entry local address 1 to 2048, zero disables
// - entry remote address 1 to 8192, zero disables
// - entry count 1 to 128, zero disables
// - direction selects read or write
// - entry valid only when all fields legal
// - valid scan entry disables auto-transfer
// - scan on modbus port forbids slave role
// - status words pack entries 1-16, 17-32, 33-48
// - auto-transfer makes the port master
`timescale 1ns/1ps

// two-entry elastic buffer; holds a word while the link stalls
module tmps_buf2 #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_q [2];  // storage words
	logic [WIDTH-1:0] mem_d [2];
	logic             rd_q, rd_d; // read slot
	logic             wr_q, wr_d; // write slot
	logic [1:0]       cnt_q, cnt_d; // words held
	logic             push, pop;

	assign in_ready  = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// next pointers and contents
	always_comb begin
		mem_d = mem_q;
		rd_d  = rd_q;
		wr_d  = wr_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wr_q] = in_data;
			wr_d        = !wr_q;
		end
		if (pop) begin
			rd_d = !rd_q;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 2'h1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 2'h1;
		end
	end

	// register stage
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			rd_q     <= 1'b0;
			wr_q     <= 1'b0;
			cnt_q    <= 2'h0;
		end else begin
			mem_q <= mem_d;
			rd_q  <= rd_d;
			wr_q  <= wr_d;
			cnt_q <= cnt_d;
		end
	end
endmodule

module tmps_sched #(
	parameter int TICK_CYCLES = tmps_pkg::TICK_CYCLES_DEF // shorten in simulation
) (
	input  wire logic                          MCLK,
	input  wire logic                          ARST_N,
	input  wire logic [tmps_pkg::IVL_W-1:0]    INTERVAL,
	input  wire logic [tmps_pkg::RTE_W-1:0]    XFER_ROUTE,
	input  wire logic [tmps_pkg::CNT_W-1:0]    RD_COUNT,
	input  wire logic [tmps_pkg::REM_W-1:0]    RD_FROM,
	input  wire logic [tmps_pkg::LOC_W-1:0]    RD_TO,
	input  wire logic [tmps_pkg::CNT_W-1:0]    WR_COUNT,
	input  wire logic [tmps_pkg::LOC_W-1:0]    WR_FROM,
	input  wire logic [tmps_pkg::REM_W-1:0]    WR_TO,
	input  wire logic                          MODBUS_MODE,
	input  wire logic                          TBL_WE,
	input  wire logic [tmps_pkg::IDX_W-1:0]    TBL_IDX,
	input  wire logic [tmps_pkg::LOC_W-1:0]    TBL_LOCAL,
	input  wire logic [tmps_pkg::REM_W-1:0]    TBL_REMOTE,
	input  wire logic [tmps_pkg::CNT_W-1:0]    TBL_COUNT,
	input  wire logic                          TBL_DIR,
	input  wire logic [tmps_pkg::RTE_W-1:0]    TBL_ROUTE,
	output logic                               REQ_VALID,
	input  wire logic                          REQ_READY,
	output logic                               REQ_DIR,
	output logic      [tmps_pkg::LOC_W-1:0]    REQ_LOCAL,
	output logic      [tmps_pkg::REM_W-1:0]    REQ_REMOTE,
	output logic      [tmps_pkg::CNT_W-1:0]    REQ_COUNT,
	output logic      [tmps_pkg::RTE_W-1:0]    REQ_ROUTE,
	output logic                               REQ_SCAN,
	output logic      [tmps_pkg::IDX_W-1:0]    REQ_IDX,
	input  wire logic                          RSP_VALID,
	input  wire logic                          RSP_OK,
	output logic      [15:0]                   STATUS_W0,
	output logic      [15:0]                   STATUS_W1,
	output logic      [15:0]                   STATUS_W2,
	output logic                               MASTER_ROLE,
	output logic                               SLAVE_EN
);
	import tmps_pkg::*;

	// scan table, flip-flops indexed by entry
	logic [LOC_W-1:0] loc_q [ENTRIES];
	logic [REM_W-1:0] rem_q [ENTRIES];
	logic [CNT_W-1:0] cnt_q [ENTRIES];
	logic             dir_q [ENTRIES];
	logic [RTE_W-1:0] rte_q [ENTRIES];
	logic [LOC_W-1:0] loc_d [ENTRIES];
	logic [REM_W-1:0] rem_d [ENTRIES];
	logic [CNT_W-1:0] cnt_d [ENTRIES];
	logic             dir_d [ENTRIES];
	logic [RTE_W-1:0] rte_d [ENTRIES];
	logic [ENTRIES-1:0] vld;            // per-entry legality
	logic               scan_active;    // any legal entry present

	// table writes
	always_comb begin
		loc_d = loc_q;
		rem_d = rem_q;
		cnt_d = cnt_q;
		dir_d = dir_q;
		rte_d = rte_q;
		if (TBL_WE && (int'(TBL_IDX) < ENTRIES)) begin
			loc_d[TBL_IDX] = TBL_LOCAL;
			rem_d[TBL_IDX] = TBL_REMOTE;
			cnt_d[TBL_IDX] = TBL_COUNT;
			dir_d[TBL_IDX] = TBL_DIR;
			rte_d[TBL_IDX] = TBL_ROUTE;
		end
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int i = 0; i < ENTRIES; i++) begin
				loc_q[i] <= '0;
				rem_q[i] <= '0;
				cnt_q[i] <= '0;
				dir_q[i] <= DIR_READ;
				rte_q[i] <= '0;
			end
		end else begin
			loc_q <= loc_d;
			rem_q <= rem_d;
			cnt_q <= cnt_d;
			dir_q <= dir_d;
			rte_q <= rte_d;
		end
	end

	// entry legality: every field but direction non-zero, addresses and count within range
	always_comb begin
		for (int i = 0; i < ENTRIES; i++) begin
			vld[i] = (loc_q[i] != '0) && (loc_q[i] <= LOC_MAX)
			      && (rem_q[i] != '0) && (rem_q[i] <= REM_MAX)
			      && (cnt_q[i] != '0) && (cnt_q[i] <= CNT_MAX)
			      && (rte_q[i] != '0);
		end
	end
	assign scan_active = |vld;

	// auto-transfer enables; suppressed as soon as the scan table is live
	logic rd_en, wr_en;
	assign rd_en = !scan_active && (RD_COUNT != '0) && (RD_COUNT <= CNT_MAX)
	            && (RD_TO != '0) && (RD_TO <= LOC_MAX) && (XFER_ROUTE != '0);
	assign wr_en = !scan_active && (WR_COUNT != '0) && (WR_COUNT <= CNT_MAX)
	            && (WR_FROM != '0) && (WR_FROM <= LOC_MAX) && (XFER_ROUTE != '0);

	// 10 ms tick from the system clock
	logic [31:0] tk_q, tk_d;
	logic        tick;
	assign tick = (tk_q == 32'(TICK_CYCLES - 1));
	always_comb begin
		tk_d = tick ? 32'h0000_0000 : tk_q + 32'h0000_0001;
	end
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tk_q <= 32'h0000_0000;
		end else begin
			tk_q <= tk_d;
		end
	end

	// next legal entry after the pointer, ascending with wrap
	logic [IDX_W-1:0] ptr_q, ptr_d;   // last entry serviced
	logic [IDX_W-1:0] nxt;
	always_comb begin
		int j;
		logic found;
		j     = 0;
		found = 1'b0;
		nxt   = ptr_q;
		for (int i = 1; i <= ENTRIES; i++) begin
			j = (int'(ptr_q) + i) % ENTRIES;
			if (!found && vld[j]) begin
				found = 1'b1;
				nxt   = IDX_W'(j);
			end
		end
	end

	// message selection
	logic             have_msg, m_dir;
	logic [LOC_W-1:0] m_loc;
	logic [REM_W-1:0] m_rem;
	logic [CNT_W-1:0] m_cnt;
	logic             alt_q, alt_d;   // 0: read goes next
	always_comb begin
		have_msg = (INTERVAL != IVL_OFF) && (scan_active || rd_en || wr_en);
		if (scan_active) begin
			m_dir = dir_q[nxt];
			m_loc = loc_q[nxt];
			m_rem = rem_q[nxt];
			m_cnt = cnt_q[nxt];
		end else if (rd_en && (!wr_en || !alt_q)) begin
			m_dir = DIR_READ;
			m_loc = RD_TO;
			m_rem = RD_FROM;
			m_cnt = RD_COUNT;
		end else begin
			m_dir = DIR_WRITE;
			m_loc = WR_FROM;
			m_rem = WR_TO;
			m_cnt = WR_COUNT;
		end
	end

	// request buffer between scheduler and link
	logic             push, in_ready;
	logic [MSG_W-1:0] in_msg, out_msg;
	assign in_msg = {m_dir, m_loc, m_rem, m_cnt,
	                 scan_active ? rte_q[nxt] : XFER_ROUTE, scan_active, scan_active ? nxt : '0};
	tmps_buf2 #(.WIDTH(MSG_W)) u_buf (
		.clk       (MCLK),
		.arst_n    (ARST_N),
		.in_valid  (push),
		.in_ready  (in_ready),
		.in_data   (in_msg),
		.out_valid (REQ_VALID),
		.out_ready (REQ_READY),
		.out_data  (out_msg)
	);
	assign {REQ_DIR, REQ_LOCAL, REQ_REMOTE, REQ_COUNT, REQ_ROUTE, REQ_SCAN, REQ_IDX} = out_msg;

	// scheduler state
	tmps_state_t       st_q, st_d;
	logic [IVL_W-1:0]  ic_q, ic_d;        // ticks in wait or hold
	logic              out_q, out_d;      // a request awaits its reply
	logic              oscan_q, oscan_d;  // outstanding one is a scan entry
	logic [IDX_W-1:0]  oidx_q, oidx_d;
	logic [ENTRIES-1:0] stat_q, stat_d;
	logic              mst_q, mst_d, slv_q, slv_d;
	logic              expire;
	assign push   = (st_q == ST_SEND) && have_msg && in_ready;
	assign expire = tick && ((ic_q + 16'h0001) >= ((st_q == ST_HOLD) ? HOLD_TICKS : INTERVAL));

	always_comb begin
		st_d    = st_q;
		ic_d    = ic_q;
		out_d   = out_q;
		oscan_d = oscan_q;
		oidx_d  = oidx_q;
		alt_d   = alt_q;
		ptr_d   = ptr_q;
		stat_d  = stat_q & vld;
		mst_d   = have_msg;
		slv_d   = !(MODBUS_MODE && scan_active);
		if (RSP_VALID && out_q) begin
			out_d = 1'b0;
			if (oscan_q) begin
				stat_d[oidx_q] = RSP_OK && vld[oidx_q];
			end
		end
		case (st_q)
			ST_IDLE: begin
				if (have_msg) begin
					st_d = ST_SEND;
				end
			end
			ST_SEND: begin
				if (!have_msg) begin
					st_d = ST_IDLE;
				end else if (in_ready) begin
					st_d    = ST_WAIT;
					ic_d    = '0;
					out_d   = 1'b1;
					oscan_d = scan_active;
					oidx_d  = nxt;
					if (scan_active) begin
						ptr_d = nxt;
					end else if (rd_en && wr_en) begin
						alt_d = !alt_q;
					end
				end
			end
			ST_WAIT: begin
				if (!have_msg) begin
					st_d = ST_IDLE;
				end else if (tick) begin
					ic_d = ic_q + 16'h0001;
					if (expire) begin
						st_d = out_d ? ST_HOLD : ST_SEND;
						ic_d = '0;
					end
				end
			end
			ST_HOLD: begin
				// late reply: hold off, then give up on it and move on
				if (tick) begin
					ic_d = ic_q + 16'h0001;
					if (expire) begin
						st_d = ST_SEND;
						ic_d = '0;
						if (out_q && oscan_q) begin
							stat_d[oidx_q] = 1'b0;
						end
						out_d = 1'b0;
					end
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_q    <= ST_IDLE;
			ic_q    <= '0;
			out_q   <= 1'b0;
			oscan_q <= 1'b0;
			oidx_q  <= '0;
			alt_q   <= 1'b0;
			ptr_q   <= IDX_W'(ENTRIES - 1);
			stat_q  <= '0;
			mst_q   <= 1'b0;
			slv_q   <= 1'b1;
		end else begin
			st_q    <= st_d;
			ic_q    <= ic_d;
			out_q   <= out_d;
			oscan_q <= oscan_d;
			oidx_q  <= oidx_d;
			alt_q   <= alt_d;
			ptr_q   <= ptr_d;
			stat_q  <= stat_d;
			mst_q   <= mst_d;
			slv_q   <= slv_d;
		end
	end

	assign STATUS_W0   = stat_q[15:0];
	assign STATUS_W1   = stat_q[31:16];
	assign STATUS_W2   = stat_q[47:32];
	assign MASTER_ROLE = mst_q;
	assign SLAVE_EN    = slv_q;

	// helper state for checks: ticks since last push, last transfer direction
	logic [IVL_W-1:0] since_q;
	logic             seen_q, ldir_q;
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			since_q <= '0;
			seen_q  <= 1'b0;
			ldir_q  <= DIR_WRITE;
		end else begin
			since_q <= push ? '0 : ((tick && (since_q != 16'hFFFF)) ? since_q + 16'h0001 : since_q);
			seen_q  <= seen_q || push;
			ldir_q  <= push ? m_dir : ldir_q;
		end
	end

	sequence late_expiry_s;
		(st_q == ST_WAIT) && expire && out_d && have_msg;
	endsequence
	sequence good_reply_s;
		RSP_VALID && out_q && oscan_q && RSP_OK && vld[oidx_q] && !(st_q == ST_HOLD && expire);
	endsequence

	spacing_ticks_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		push && seen_q |-> since_q >= INTERVAL) else $error("messages closer than interval");
	alt_dir_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		push && rd_en && wr_en |-> m_dir != ldir_q) else $error("read and write not alternating");
	late_hold_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		late_expiry_s |=> (st_q == ST_HOLD) && !push) else $error("no hold after late reply");
	zero_ivl_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		INTERVAL == IVL_OFF |-> !push) else $error("message sent with zero interval");
	rd_limit_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		push && !scan_active && m_dir == DIR_READ |-> m_cnt != '0 && m_cnt <= CNT_MAX && m_loc <= LOC_MAX)
		else $error("illegal auto-transfer read");
	scan_valid_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		push && scan_active |-> vld[nxt] && in_msg[IDX_W]) else $error("invalid scan entry sent");
	xfer_off_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		scan_active && push |-> m_loc == loc_q[nxt]) else $error("auto-transfer ran beside scan");
	slave_off_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		MODBUS_MODE && scan_active |=> !SLAVE_EN) else $error("slave allowed during scan");
	status_set_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		good_reply_s |=> stat_q[$past(oidx_q)]) else $error("status bit not set on good reply");
	one_out_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		push |-> !out_q) else $error("second request while one outstanding");
endmodule

/* sim/tb_top.sv */
// self-checking bench for the poll scheduler: transfer and scan traffic, late reply, status words
// assumes a short tick so the two second hold fits in a short run
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
	import tmps_pkg::*;
	localparam int TK = 4; // clocks per tick in this run
	logic MCLK = 0, ARST_N = 0, MODBUS_MODE = 0, TBL_WE = 0, TBL_DIR = 0;
	logic REQ_READY, RSP_VALID, RSP_OK, REQ_VALID, REQ_DIR, REQ_SCAN, MASTER_ROLE, SLAVE_EN;
	logic [15:0] INTERVAL = 0, STATUS_W0, STATUS_W1, STATUS_W2;
	logic [7:0]  XFER_ROUTE = 0, RD_COUNT = 0, WR_COUNT = 0, TBL_COUNT = 0, TBL_ROUTE = 0, REQ_COUNT, REQ_ROUTE;
	logic [13:0] RD_FROM = 0, WR_TO = 0, TBL_REMOTE = 0, REQ_REMOTE;
	logic [11:0] RD_TO = 0, WR_FROM = 0, TBL_LOCAL = 0, REQ_LOCAL;
	logic [5:0]  TBL_IDX = 0, REQ_IDX;
	logic [49:0] q[$], ent[64], got, exp;
	int          n_fail = 0, num_checks = 0, seed = 89360, cyc_n = 0, last = 0, lo = 0, hi = 0, k;
	int          ph_n = 0, ph_seen = -1; // phase count; first word of a phase has no gap to judge
	logic        stall_on = 0, rb = 0, mute_en = 0;
	always #20 MCLK = ~MCLK;
	tmps_sched #(.TICK_CYCLES(TK)) tmps_sched_inst (.MCLK(MCLK), .ARST_N(ARST_N), .INTERVAL(INTERVAL),
		.XFER_ROUTE(XFER_ROUTE), .RD_COUNT(RD_COUNT), .RD_FROM(RD_FROM), .RD_TO(RD_TO), .WR_COUNT(WR_COUNT),
		.WR_FROM(WR_FROM), .WR_TO(WR_TO), .MODBUS_MODE(MODBUS_MODE), .TBL_WE(TBL_WE), .TBL_IDX(TBL_IDX),
		.TBL_LOCAL(TBL_LOCAL), .TBL_REMOTE(TBL_REMOTE), .TBL_COUNT(TBL_COUNT), .TBL_DIR(TBL_DIR),
		.TBL_ROUTE(TBL_ROUTE), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ_DIR(REQ_DIR),
		.REQ_LOCAL(REQ_LOCAL), .REQ_REMOTE(REQ_REMOTE), .REQ_COUNT(REQ_COUNT), .REQ_ROUTE(REQ_ROUTE),
		.REQ_SCAN(REQ_SCAN), .REQ_IDX(REQ_IDX), .RSP_VALID(RSP_VALID), .RSP_OK(RSP_OK), .STATUS_W0(STATUS_W0),
		.STATUS_W1(STATUS_W1), .STATUS_W2(STATUS_W2), .MASTER_ROLE(MASTER_ROLE), .SLAVE_EN(SLAVE_EN));
	// scan entry 47 always gets an error reply; entry 0 can be left unanswered
	tmps_link_model tmps_link_model_inst (.clk(MCLK), .arst_n(ARST_N), .req_valid(REQ_VALID),
		.req_ready(REQ_READY), .rsp_valid(RSP_VALID), .rsp_ok(RSP_OK), .stall(rb),
		.mute(mute_en && REQ_SCAN && REQ_IDX == 6'd0), .ok(!(REQ_SCAN && REQ_IDX == 6'd47)));
	function automatic logic [49:0] m(input logic s, input logic [5:0] i, input logic d, input logic [11:0] l,
		input logic [13:0] r, input logic [7:0] c, input logic [7:0] t);
		return {s, i, d, l, r, c, t};
	endfunction
	task automatic wrap_up();
		if (n_fail == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask
	task automatic do_reset();
		ARST_N = 0;
		cyc(8);
		ARST_N = 1;
	endtask
	// start a phase: new interval, first gap not judged
	task automatic go(input logic [15:0] v);
		INTERVAL = v;
		ph_n++;
		lo       = (v - 1) * TK;
		hi       = (v + 1) * TK + 4;
		cyc(v == 0 ? 60 : 1);
	endtask
	// bounded wait until every noted message has been seen
	task automatic drain();
		for (int i = 0; i < 1500 && q.size() > 0; i++) cyc(1);
		`CHK("drain", 0, q.size())
	endtask
	task automatic tw(input int i, input logic [11:0] l, input logic [13:0] r, input logic [7:0] c,
		input logic d, input logic [7:0] t);
		TBL_IDX = 6'(i); TBL_LOCAL = l; TBL_REMOTE = r; TBL_COUNT = c; TBL_DIR = d; TBL_ROUTE = t;
		TBL_WE = 1;
		ent[i] = m(1'b1, 6'(i), d, l, r, c, t);
		cyc(1);
		TBL_WE = 0;
		// let an edge pass so a following write never lowers and raises the strobe in one step
		cyc(1);
	endtask
	// random ready stalls, only where gaps are not judged
	always @(posedge MCLK) begin
		#1 rb = stall_on & ($random(seed) % 3 == 0);
	end
	// watcher: each accepted word is matched to the oldest note, gap checked against the interval
	always @(posedge MCLK) begin
		cyc_n++;
		if (cyc_n == 40000) begin
			n_fail++;
			wrap_up();
		end else if (ARST_N && REQ_VALID === 1'b1 && REQ_READY) begin
			got = {REQ_SCAN, REQ_IDX, REQ_DIR, REQ_LOCAL, REQ_REMOTE, REQ_COUNT, REQ_ROUTE};
			exp = q.size() ? q.pop_front() : 'x;
			`CHK("msg", exp, got)
			if (ph_seen == ph_n && !stall_on) `CHK("gap", 1'b1, cyc_n - last >= lo && cyc_n - last <= hi)
			ph_seen = ph_n;
			last    = cyc_n;
		end
	end
	initial begin
		XFER_ROUTE = 8'h7D; RD_COUNT = 8'h80; RD_TO = 12'h800; WR_COUNT = 8'h01; WR_FROM = 12'h001;
		RD_FROM = 14'($random(seed)); WR_TO = 14'($random(seed));
		do_reset();
		MODBUS_MODE = 1;
		cyc(60);
		`CHK("role", 1'b0, MASTER_ROLE)
		go(3);
		for (k = 0; k < 4; k++) q.push_back(m(0, 0, k[0], k[0] ? WR_FROM : RD_TO, k[0] ? WR_TO : RD_FROM,
			k[0] ? WR_COUNT : RD_COUNT, XFER_ROUTE));
		drain();
		`CHK("role", 1'b1, MASTER_ROLE)
		`CHK("slave", 1'b1, SLAVE_EN)
		// illegal read settings leave only writes, under random stalls
		stall_on = 1;
		for (k = 0; k < 4; k++) begin
			go(0);
			RD_COUNT = k == 0 ? 8'h00 : k == 1 ? 8'h81 : 8'h80;
			RD_TO    = k == 2 ? 12'h000 : k == 3 ? 12'h801 : 12'h800;
			go(3);
			q.push_back(m(0, 0, DIR_WRITE, WR_FROM, WR_TO, WR_COUNT, XFER_ROUTE));
			q.push_back(m(0, 0, DIR_WRITE, WR_FROM, WR_TO, WR_COUNT, XFER_ROUTE));
			drain();
		end
		stall_on = 0;
		go(0);
		RD_COUNT = 8'h80; RD_TO = 12'h800; WR_COUNT = 8'h00;
		go(3);
		for (k = 0; k < 3; k++) q.push_back(m(0, 0, DIR_READ, RD_TO, RD_FROM, RD_COUNT, XFER_ROUTE));
		drain();
		go(0);
		// scan table after a fresh reset; transfer stays configured but must stay quiet
		WR_COUNT = 8'h01;
		do_reset();
		tw(0, 12'h001, 14'($random(seed)) & 14'h1FFF | 14'h0001, 8'h01, DIR_READ, 8'h11);
		tw(17, 12'h123, 14'h2000, 8'h80, DIR_WRITE, 8'h22);
		tw(47, 12'h800, 14'h0001, 8'h05, DIR_READ, 8'h33);
		for (k = 1; k < 8; k++) tw(k, k == 2 ? 12'h000 : k == 5 ? 12'h801 : 12'h005,
			k == 3 ? 14'h0000 : k == 6 ? 14'h2001 : 14'h0009, k == 1 ? 8'h00 : k == 7 ? 8'h81 : 8'h04,
			DIR_READ, k == 4 ? 8'h00 : 8'h44);
		tw(48, 12'h001, 14'h0001, 8'h01, DIR_READ, 8'h55);
		// slave role only withdrawn on a modbus-mode port
		MODBUS_MODE = 0;
		cyc(2);
		`CHK("slave", 1'b1, SLAVE_EN)
		MODBUS_MODE = 1;
		go(3);
		`CHK("slave", 1'b0, SLAVE_EN)
		for (k = 0; k < 6; k++) q.push_back(ent[k % 3 == 0 ? 0 : k % 3 == 1 ? 17 : 47]);
		drain();
		cyc(8);
		`CHK("st0", 1'b1, STATUS_W0[0])
		`CHK("st17", 1'b1, STATUS_W1[1])
		`CHK("st47", 1'b0, STATUS_W2[15])
		// entry 0 goes unanswered: the next word waits the extra hold
		mute_en = 1;
		q.push_back(ent[0]);
		drain();
		mute_en = 0;
		lo = (3 + 199) * TK;
		hi = (3 + 201) * TK + 4;
		q.push_back(ent[17]);
		drain();
		lo = 2 * TK;
		hi = 4 * TK + 4;
		`CHK("st0", 1'b0, STATUS_W0[0])
		tw(17, 12'h123, 14'h2000, 8'h00, DIR_WRITE, 8'h22);
		cyc(2);
		`CHK("st17", 1'b0, STATUS_W1[1])
		q.push_back(ent[47]);
		q.push_back(ent[0]);
		q.push_back(ent[47]);
		drain();
		go(0);
		cyc(200);
		`CHK("role", 1'b0, MASTER_ROLE)
		wrap_up();
	end
endmodule

/* sim/tmps_link_model.sv */
// far-side serial link model: takes request words, answers each unmuted one after a short delay
// assumes the scheduler keeps at most one request outstanding
`timescale 1ns/1ps
module tmps_link_model (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic req_valid,
	output logic      req_ready,
	output logic      rsp_valid,
	output logic      rsp_ok,
	input  wire logic stall,
	input  wire logic mute,
	input  wire logic ok
);
	logic [1:0] cnt_q;  // cycles left before the reply
	logic       busy_q; // a reply is owed
	logic       ok_q;   // verdict of the owed reply
	logic       junk_q; // toggles so an idle ok line never looks stable
	assign req_ready = !stall;
	assign rsp_ok    = rsp_valid ? ok_q : junk_q;
	// reply comes well inside one interval unless muted
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_q    <= 1'b0;
			cnt_q     <= 2'd0;
			ok_q      <= 1'b0;
			junk_q    <= 1'b0;
			rsp_valid <= 1'b0;
		end else begin
			junk_q    <= !junk_q;
			rsp_valid <= busy_q && cnt_q == 2'd0;
			if (busy_q && cnt_q == 2'd0) begin
				busy_q <= 1'b0;
			end else begin
				cnt_q <= cnt_q - 2'd1;
			end
			// a muted request is never answered, as a dead slave would
			if (req_valid && req_ready) begin
				busy_q <= !mute;
				cnt_q  <= 2'd2;
				ok_q   <= ok;
			end
		end
	end
endmodule
